// file: inc/tcpr_defs.svh
// Constants for the Type-C port role logic: offsets, fields, resets, timing
// Summary of operation
// - Enable falling edge or soft reset restores dual-role
// - GPIO mode allows dual-role only
// - Source-only presents Rp both pins, watches Rd
// - VCONN to unconnected pin only when Ra
// - Sink-only presents Rd both pins, reads level
// - Sink attach needs CC debounce and VBUS
// - Attached sink reports detected source current
// - Dual-role alternates Rp and Rd presentation
// - Attached source drives attach indicator low
// - GPIO mode advertises default current only
// - Try.SRC only in I2C mode
// - Preference 2'b11 enables Try.SRC
// - Default advertisement, writes raise to medium/high
// - Rp level follows advertised current setting
// - Audio accessory output low, or readable
// - Below-Ra on both pins means audio
// - Source sees Rd both: debug 3'b110
// - Sink sees Rp both: debug 3'b111
// - No charge-through debug as dual-role or sink
// - Floating strap selects GPIO, else I2C
// - Orientation low for CC1, high for CC2
// - Register updates set interrupt, host clears
`ifndef TCPR_DEFS_SVH
`define TCPR_DEFS_SVH

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define TCPR_CLK_KHZ 40000
`define TCPR_CC_DB_MS 168
`define TCPR_DRP_MS 75
`define TCPR_DRP_SRC_PCT 30
`define TCPR_TRY_MS 100

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define TCPR_ADDR_CURRENT 8'h08
`define TCPR_ADDR_STATUS 8'h09
`define TCPR_ADDR_ROLE 8'h0A

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define TCPR_TERM_DIS_BIT 0
`define TCPR_PREF_LSB 1
`define TCPR_SOFT_RST_BIT 3
`define TCPR_ROLE_LSB 4
`define TCPR_ROLE_MASK 8'h37
`define TCPR_ADV_LSB 6
`define TCPR_INT_BIT 4
`define TCPR_ROLE_RST 8'h00
`define TCPR_ADV_RST 2'h0
`define TCPR_PREF_TRY_SRC 2'h3
`define TCPR_CUR_DEF 2'h0
`define TCPR_CUR_MED 2'h1
`define TCPR_CUR_HIGH 2'h2
`define TCPR_ACC_NONE 3'h0
`define TCPR_ACC_AUDIO 3'h4
`define TCPR_ACC_DBG_SRC 3'h6
`define TCPR_ACC_DBG_SNK 3'h7

`endif

// file: inc/tcpr_pkg.sv
// Types shared by the Type-C port role logic
`default_nettype none
package tcpr_pkg;
	// Decoded CC comparator level
	typedef enum logic [2:0] {CC_OPEN = 3'h0, CC_RA = 3'h1, CC_RD = 3'h2, CC_RP_DEF = 3'h3,
		CC_RP_MED = 3'h4, CC_RP_HIGH = 3'h5, CC_AUDIO = 3'h6} tcpr_cc_type;
	typedef enum logic [1:0] {ROLE_DRP = 2'h0, ROLE_SNK = 2'h1, ROLE_SRC = 2'h2} tcpr_role_type;
	typedef enum logic [10:0] {
		ST_DISABLED = 11'h001, ST_UNATT_SNK = 11'h002, ST_ATTWAIT_SNK = 11'h004,
		ST_ATT_SNK = 11'h008, ST_UNATT_SRC = 11'h010, ST_ATTWAIT_SRC = 11'h020,
		ST_ATT_SRC = 11'h040, ST_TRY_SRC = 11'h080, ST_TRYWAIT_SNK = 11'h100,
		ST_AUDIO = 11'h200, ST_DEBUG = 11'h400} tcpr_state_type;
endpackage
`default_nettype wire

// file: src/tcpr_port_role.sv
// Type-C port role state machine, terminations, reporting and registers
`timescale 1ns/10ps
`default_nettype none
`include "tcpr_defs.svh"
module tcpr_port_role
	import tcpr_pkg::*;
#(
	parameter int CNT_W = 24,
	parameter int DB_CYC = `TCPR_CC_DB_MS * `TCPR_CLK_KHZ,
	parameter int DRP_CYC = `TCPR_DRP_MS * `TCPR_CLK_KHZ,
	parameter int DRP_SRC_CYC = `TCPR_DRP_MS * `TCPR_CLK_KHZ * `TCPR_DRP_SRC_PCT / 100,
	parameter int TRY_CYC = `TCPR_TRY_MS * `TCPR_CLK_KHZ
)(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic enable_low_pin,
	input wire logic addr_float_pin,
	input wire logic vbus_det_pin,
	input wire logic [2:0] cc1_level,
	input wire logic [2:0] cc2_level,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic cc1_rp_en,
	output logic cc2_rp_en,
	output logic cc1_rd_en,
	output logic cc2_rd_en,
	output logic [1:0] rp_level,
	output logic vconn_cc1_en,
	output logic vconn_cc2_en,
	output logic attach_indicator_pin_oe,
	output logic orientation_out_oe,
	output logic current_out_a_oe,
	output logic current_out_b_oe,
	output logic audio_accessory_out_oe,
	output logic interrupt_out_low_oe,
	output logic gpio_mode
);
	localparam logic [CNT_W-1:0] DB_L = CNT_W'(DB_CYC);
	localparam logic [CNT_W-1:0] SRC_L = CNT_W'(DRP_SRC_CYC);
	localparam logic [CNT_W-1:0] SNK_L = CNT_W'(DRP_CYC - DRP_SRC_CYC);
	localparam logic [CNT_W-1:0] TRY_L = CNT_W'(TRY_CYC);

	// ---------------------------------------------------------------
	// Pin synchronisation and strap capture
	// ---------------------------------------------------------------
	logic [8:0] sync_w;
	tcpr_sync #(.W(9)) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.async_in({addr_float_pin, enable_low_pin, vbus_det_pin, cc2_level, cc1_level}),
		.sync_out(sync_w)
	);
	tcpr_cc_type cc1_s, cc2_s;
	logic vbus_s, en_s, addr_s;
	assign cc1_s = tcpr_cc_type'(sync_w[2:0]);
	assign cc2_s = tcpr_cc_type'(sync_w[5:3]);
	assign vbus_s = sync_w[6];
	assign en_s = sync_w[7];
	assign addr_s = sync_w[8];

	logic [1:0] strap_cnt_r, strap_cnt_nxt;
	logic gpio_mode_r, gpio_mode_nxt, en_d_r;
	logic strap_done, en_fall, shutdown;
	assign strap_done = (strap_cnt_r == 2'h3);
	assign en_fall = en_d_r & ~en_s;
	assign shutdown = en_s;

	// Strap is sampled after the synchroniser has filled, then frozen
	always_comb
	begin
		strap_cnt_nxt = strap_cnt_r;
		gpio_mode_nxt = gpio_mode_r;
		if (!strap_done)
		begin
			strap_cnt_nxt = strap_cnt_r + 2'h1;
			gpio_mode_nxt = addr_s;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			strap_cnt_r <= 2'h0;
			gpio_mode_r <= 1'b0;
			en_d_r <= 1'b0;
		end
		else
		begin
			strap_cnt_r <= strap_cnt_nxt;
			gpio_mode_r <= gpio_mode_nxt;
			en_d_r <= en_s;
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [7:0] role_r, role_nxt, rdata_nxt;
	logic [1:0] adv_r, adv_nxt, det_r, det_nxt, att_r, att_nxt;
	logic [2:0] acc_r, acc_nxt;
	logic int_r, int_nxt, orient_r, orient_nxt, ev, role_reset, term_dis;
	tcpr_role_type eff_role;
	logic drp, try_en;

	assign role_reset = en_fall | (reg_wr_en && reg_addr == `TCPR_ADDR_ROLE
		&& reg_wdata[`TCPR_SOFT_RST_BIT]);
	assign term_dis = role_r[`TCPR_TERM_DIS_BIT];

	// Role select takes effect from the unattached states; GPIO mode forces dual-role whatever it holds
	always_comb
	begin
		if (gpio_mode_r)
			eff_role = ROLE_DRP;
		else if (role_r[`TCPR_ROLE_LSB+:2] == ROLE_SNK)
			eff_role = ROLE_SNK;
		else if (role_r[`TCPR_ROLE_LSB+:2] == ROLE_SRC)
			eff_role = ROLE_SRC;
		else
			eff_role = ROLE_DRP;
	end
	assign drp = (eff_role == ROLE_DRP);
	// GPIO strap forbids any role preference
	assign try_en = drp && !gpio_mode_r
		&& role_r[`TCPR_PREF_LSB+:2] == `TCPR_PREF_TRY_SRC;

	// Write decode; a new event wins over a clear in the same cycle
	always_comb
	begin
		role_nxt = role_r;
		adv_nxt = adv_r;
		int_nxt = int_r;
		rdata_nxt = reg_rdata;
		if (reg_wr_en && reg_addr == `TCPR_ADDR_ROLE)
			role_nxt = reg_wdata & `TCPR_ROLE_MASK;
		if (role_reset)
			role_nxt[`TCPR_ROLE_LSB+:2] = ROLE_DRP;
		if (reg_wr_en && reg_addr == `TCPR_ADDR_CURRENT)
			adv_nxt = reg_wdata[`TCPR_ADV_LSB+:2];
		if (reg_wr_en && reg_addr == `TCPR_ADDR_STATUS && reg_wdata[`TCPR_INT_BIT])
			int_nxt = 1'b0;
		if (ev)
			int_nxt = 1'b1;
		if (reg_rd_en)
		begin
			unique case (reg_addr)
				`TCPR_ADDR_CURRENT: rdata_nxt = {adv_r, det_r, acc_r, 1'b0};
				`TCPR_ADDR_STATUS: rdata_nxt = {att_r, orient_r, int_r, 3'h0, gpio_mode_r};
				`TCPR_ADDR_ROLE: rdata_nxt = role_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			role_r <= `TCPR_ROLE_RST;
			adv_r <= `TCPR_ADV_RST;
			int_r <= 1'b0;
			reg_rdata <= 8'h00;
		end
		else
		begin
			role_r <= role_nxt;
			adv_r <= adv_nxt;
			int_r <= int_nxt;
			reg_rdata <= rdata_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Attach state machine
	// ---------------------------------------------------------------
	tcpr_state_type st_r, st_nxt, home;
	logic [CNT_W-1:0] tmr_r, tmr_nxt;
	logic [5:0] cc_prev_r;
	logic rp1, rp2, rd1, rd2, aud, db_done, cc_chg;
	assign rp1 = (cc1_s == CC_RP_DEF) || (cc1_s == CC_RP_MED) || (cc1_s == CC_RP_HIGH);
	assign rp2 = (cc2_s == CC_RP_DEF) || (cc2_s == CC_RP_MED) || (cc2_s == CC_RP_HIGH);
	assign rd1 = (cc1_s == CC_RD);
	assign rd2 = (cc2_s == CC_RD);
	assign aud = (cc1_s == CC_AUDIO) && (cc2_s == CC_AUDIO);
	assign db_done = (tmr_r >= DB_L);
	assign cc_chg = ({cc2_s, cc1_s} != cc_prev_r);
	assign home = (eff_role == ROLE_SRC) ? ST_UNATT_SRC : ST_UNATT_SNK;

	// Next state; termination disable overrides the case; shutdown, role resets and strap wait override all
	always_comb
	begin
		st_nxt = st_r;
		orient_nxt = orient_r;
		acc_nxt = acc_r;
		unique case (st_r)
			ST_DISABLED: if (!term_dis) st_nxt = home;
			ST_UNATT_SNK:
				if (eff_role == ROLE_SRC) st_nxt = ST_UNATT_SRC;
				else if (rp1 || rp2) st_nxt = ST_ATTWAIT_SNK;
				else if (drp && tmr_r >= SNK_L) st_nxt = ST_UNATT_SRC;
			ST_ATTWAIT_SNK:
				if (!(rp1 || rp2)) st_nxt = ST_UNATT_SNK;
				else if (db_done && vbus_s)
				begin
					orient_nxt = !rp1;
					if (rp1 && rp2)
					begin
						st_nxt = ST_DEBUG;
						acc_nxt = `TCPR_ACC_DBG_SNK;
					end
					else if (try_en) st_nxt = ST_TRY_SRC;
					else st_nxt = ST_ATT_SNK;
				end
			ST_ATT_SNK: if (!vbus_s) st_nxt = home;
			ST_UNATT_SRC:
				if (eff_role == ROLE_SNK) st_nxt = ST_UNATT_SNK;
				else if (rd1 || rd2 || aud) st_nxt = ST_ATTWAIT_SRC;
				else if (drp && tmr_r >= SRC_L) st_nxt = ST_UNATT_SNK;
			ST_ATTWAIT_SRC:
				if (!(rd1 || rd2 || aud)) st_nxt = home;
				else if (db_done)
				begin
					orient_nxt = !rd1;
					if (rd1 && rd2)
					begin
						st_nxt = ST_DEBUG;
						acc_nxt = `TCPR_ACC_DBG_SRC;
					end
					else if (aud) st_nxt = ST_AUDIO;
					else st_nxt = ST_ATT_SRC;
				end
			ST_ATT_SRC: if (orient_r ? !rd2 : !rd1) st_nxt = home;
			ST_TRY_SRC:
				if ((rd1 || rd2) && tmr_r >= TRY_L)
				begin
					st_nxt = ST_ATT_SRC;
					orient_nxt = !rd1;
				end
				else if (!(rd1 || rd2) && tmr_r >= TRY_L) st_nxt = ST_TRYWAIT_SNK;
			ST_TRYWAIT_SNK:
				if ((rp1 || rp2) && vbus_s && db_done)
				begin
					st_nxt = ST_ATT_SNK;
					orient_nxt = !rp1;
				end
				else if (!(rp1 || rp2) && tmr_r >= TRY_L) st_nxt = ST_UNATT_SNK;
			ST_AUDIO: if (!aud) st_nxt = home;
			ST_DEBUG:
				if (acc_r == `TCPR_ACC_DBG_SRC ? !(rd1 && rd2) : !(rp1 && rp2) || !vbus_s)
					st_nxt = home;
		endcase
		if (term_dis) st_nxt = ST_DISABLED;
		if (shutdown || role_reset || !strap_done) st_nxt = ST_UNATT_SNK;
		if (st_nxt == ST_AUDIO) acc_nxt = `TCPR_ACC_AUDIO;
		else if (st_nxt != ST_DEBUG) acc_nxt = `TCPR_ACC_NONE;
		// Timer restarts whenever the state or the CC picture changes
		tmr_nxt = (st_nxt != st_r || cc_chg) ? '0 : (&tmr_r ? tmr_r : tmr_r + 1'b1);
	end

	// Detected current and attach summary for status and interrupt
	always_comb
	begin
		det_nxt = `TCPR_CUR_DEF;
		att_nxt = 2'h0;
		if (st_nxt == ST_ATT_SNK)
		begin
			att_nxt = 2'h2;
			if ((orient_nxt ? cc2_s : cc1_s) == CC_RP_MED) det_nxt = `TCPR_CUR_MED;
			if ((orient_nxt ? cc2_s : cc1_s) == CC_RP_HIGH) det_nxt = `TCPR_CUR_HIGH;
		end
		else if (st_nxt == ST_ATT_SRC) att_nxt = 2'h1;
		else if (st_nxt == ST_AUDIO || st_nxt == ST_DEBUG) att_nxt = 2'h3;
		ev = (att_nxt != att_r) || (acc_nxt != acc_r) || (det_nxt != det_r);
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			st_r <= ST_UNATT_SNK;
			tmr_r <= '0;
			cc_prev_r <= 6'h00;
			orient_r <= 1'b0;
			acc_r <= `TCPR_ACC_NONE;
			det_r <= `TCPR_CUR_DEF;
			att_r <= 2'h0;
		end
		else
		begin
			st_r <= st_nxt;
			tmr_r <= tmr_nxt;
			cc_prev_r <= {cc2_s, cc1_s};
			orient_r <= orient_nxt;
			acc_r <= acc_nxt;
			det_r <= det_nxt;
			att_r <= att_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Terminations and pins, all registered
	// ---------------------------------------------------------------
	logic src_st, snk_att;
	assign src_st = (st_r == ST_UNATT_SRC) || (st_r == ST_ATTWAIT_SRC) || (st_r == ST_ATT_SRC)
		|| (st_r == ST_TRY_SRC) || (st_r == ST_AUDIO)
		|| (st_r == ST_DEBUG && acc_r == `TCPR_ACC_DBG_SRC);
	assign snk_att = (st_r == ST_ATT_SNK);

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			cc1_rp_en <= 1'b0;
			cc2_rp_en <= 1'b0;
			cc1_rd_en <= 1'b0;
			cc2_rd_en <= 1'b0;
			rp_level <= `TCPR_CUR_DEF;
			vconn_cc1_en <= 1'b0;
			vconn_cc2_en <= 1'b0;
			attach_indicator_pin_oe <= 1'b0;
			orientation_out_oe <= 1'b0;
			current_out_a_oe <= 1'b0;
			current_out_b_oe <= 1'b0;
			audio_accessory_out_oe <= 1'b0;
			interrupt_out_low_oe <= 1'b0;
			gpio_mode <= 1'b0;
		end
		else
		begin
			cc1_rp_en <= src_st;
			cc2_rp_en <= src_st;
			cc1_rd_en <= !src_st && st_r != ST_DISABLED;
			cc2_rd_en <= !src_st && st_r != ST_DISABLED;
			rp_level <= gpio_mode_r ? `TCPR_CUR_DEF : adv_r;
			vconn_cc1_en <= st_r == ST_ATT_SRC && orient_r && cc1_s == CC_RA;
			vconn_cc2_en <= st_r == ST_ATT_SRC && !orient_r && cc2_s == CC_RA;
			attach_indicator_pin_oe <= (st_r == ST_ATT_SRC);
			orientation_out_oe <= (st_r == ST_ATT_SRC || snk_att) && !orient_r;
			current_out_a_oe <= gpio_mode_r && snk_att && det_r != `TCPR_CUR_DEF;
			current_out_b_oe <= gpio_mode_r && snk_att && det_r != `TCPR_CUR_MED;
			audio_accessory_out_oe <= gpio_mode_r && st_r == ST_AUDIO;
			interrupt_out_low_oe <= !gpio_mode_r && int_r;
			gpio_mode <= gpio_mode_r;
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_vconn_ra;
		(st_r == ST_ATT_SRC && (orient_r ? cc1_s : cc2_s) == CC_RA)
			|=> (orient_r ? (vconn_cc1_en && !vconn_cc2_en) : (vconn_cc2_en && !vconn_cc1_en));
	endproperty
	a_vconn_ra: assert property (p_vconn_ra) else $error("VCONN not on Ra pin");
	property p_vconn_only_src;
		(vconn_cc1_en || vconn_cc2_en) |-> $past(st_r) == ST_ATT_SRC;
	endproperty
	a_vconn_only_src: assert property (p_vconn_only_src) else $error("VCONN outside source");
	property p_src_rp;
		st_r == ST_ATT_SRC |=> cc1_rp_en && cc2_rp_en && !cc1_rd_en && attach_indicator_pin_oe;
	endproperty
	a_src_rp: assert property (p_src_rp) else $error("Source terminations wrong");
	property p_snk_rd;
		st_r == ST_ATT_SNK |=> cc1_rd_en && cc2_rd_en && !cc2_rp_en;
	endproperty
	a_snk_rd: assert property (p_snk_rd) else $error("Sink terminations wrong");
	property p_snk_attach;
		(st_r == ST_ATTWAIT_SNK && st_nxt == ST_ATT_SNK) |-> vbus_s && tmr_r >= DB_L;
	endproperty
	a_snk_attach: assert property (p_snk_attach) else $error("Sink attach early");
	property p_gpio_default;
		gpio_mode_r ##1 gpio_mode_r |-> rp_level == `TCPR_CUR_DEF && st_r != ST_TRY_SRC;
	endproperty
	a_gpio_default: assert property (p_gpio_default) else $error("GPIO mode misbehaves");
	property p_term_off;
		st_r == ST_DISABLED |=> !cc1_rp_en && !cc2_rp_en && !cc1_rd_en && !cc2_rd_en;
	endproperty
	a_term_off: assert property (p_term_off) else $error("Terminations left on");
	property p_int_set;
		(ev && !gpio_mode_r) |=> int_r ##1 interrupt_out_low_oe;
	endproperty
	a_int_set: assert property (p_int_set) else $error("Interrupt not raised");
	property p_role_reset;
		role_reset |=> role_r[`TCPR_ROLE_LSB+:2] == ROLE_DRP && st_r == ST_UNATT_SNK;
	endproperty
	a_role_reset: assert property (p_role_reset) else $error("Dual-role not restored");
	property p_dbg_src;
		(st_r == ST_ATTWAIT_SRC && st_nxt == ST_DEBUG) |=> acc_r == `TCPR_ACC_DBG_SRC;
	endproperty
	a_dbg_src: assert property (p_dbg_src) else $error("Debug code wrong");

	c_att_src: cover property (st_r == ST_ATTWAIT_SRC ##1 st_r == ST_ATT_SRC);
	c_att_snk: cover property (st_r == ST_ATTWAIT_SNK ##1 st_r == ST_ATT_SNK);
	c_audio: cover property (st_r == ST_AUDIO ##1 audio_accessory_out_oe);
	c_try: cover property (st_r == ST_TRY_SRC ##1 st_r == ST_TRYWAIT_SNK);
endmodule
`default_nettype wire

// file: src/tcpr_sync.sv
// Two-flop synchroniser for the pin inputs of the port role logic
`timescale 1ns/10ps
`default_nettype none
module tcpr_sync #(
	parameter int W = 1
)(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	// One pair of flops per bit; only the second flop is visible outside
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			always_ff @(posedge clk)
			begin
				if (sys_rst)
				begin
					meta_r[i] <= 1'b0;
					sync_r[i] <= 1'b0;
				end
				else
				begin
					meta_r[i] <= async_in[i];
					sync_r[i] <= meta_r[i];
				end
			end
		end
	endgenerate

	assign sync_out = sync_r;
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the Type-C port role logic
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clk, sys_rst, enable_low_pin, addr_float_pin, vbus_on, vbus_det_pin;
	logic reg_wr_en, reg_rd_en, a, b, rp1, rp2, rd1, rd2, vc1, vc2, att, ori;
	logic ca, cb, aud, irq, gm;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic [2:0] kind, cc1_level, cc2_level;
	logic [1:0] rpl;
	int failures, n_tests, i;

	// ----------
	// Design, partner and clock
	// ----------
	// Short counts keep debounce and toggle phases within a few hundred cycles
	tcpr_port_role #(.DB_CYC(20), .DRP_CYC(100), .DRP_SRC_CYC(30), .TRY_CYC(20)) tcpr_port_role_i (
		.clk(clk), .sys_rst(sys_rst), .enable_low_pin(enable_low_pin),
		.addr_float_pin(addr_float_pin), .vbus_det_pin(vbus_det_pin),
		.cc1_level(cc1_level), .cc2_level(cc2_level), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .cc1_rp_en(rp1), .cc2_rp_en(rp2), .cc1_rd_en(rd1),
		.cc2_rd_en(rd2), .rp_level(rpl), .vconn_cc1_en(vc1), .vconn_cc2_en(vc2),
		.attach_indicator_pin_oe(att), .orientation_out_oe(ori), .current_out_a_oe(ca),
		.current_out_b_oe(cb), .audio_accessory_out_oe(aud),
		.interrupt_out_low_oe(irq), .gpio_mode(gm));
	tcpr_far_model tcpr_far_model_i (.kind(kind), .vbus_on(vbus_on), .cc1_rp_en(rp1),
		.cc2_rp_en(rp2), .cc1_rd_en(rd1), .cc2_rd_en(rd2), .cc1_level(cc1_level),
		.cc2_level(cc2_level), .vbus_det_pin(vbus_det_pin));

	// Free-running 40 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ----------
	// Shared tasks
	// ----------
	// Inputs always move 2 ns after a rising edge
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Idle edge after each strobe so it is never raised in the step it fell
	task automatic wr(input logic [7:0] ad, input logic [7:0] dat);
		reg_addr = ad;
		reg_wdata = dat;
		reg_wr_en = 1'b1;
		step(1);
		reg_wr_en = 1'b0;
		step(1);
	endtask

	task automatic rd(input logic [7:0] ad, output logic [7:0] q);
		reg_addr = ad;
		reg_rd_en = 1'b1;
		step(1);
		reg_rd_en = 1'b0;
		step(1);
		q = reg_rdata;
	endtask

	// Strap is captured a few edges after release
	task automatic do_reset();
		sys_rst = 1'b1;
		step(16);
		sys_rst = 1'b0;
		step(6);
	endtask

	// Role change with terminations pulled off meanwhile
	task automatic set_role(input logic [1:0] r);
		wr(8'h0A, 8'h01);
		wr(8'h0A, {2'h0, r, 4'h1});
		step(3);
		chk("term off", {4'h0, rp1, rp2, rd1, rd2}, 8'h00);
		wr(8'h0A, {2'h0, r, 4'h0});
		rd(8'h0A, d);
		chk("role", d, {2'h0, r, 4'h0});
	endtask

	// Waits for the start of a sink phase of the dual-role toggle
	task automatic to_sink_phase();
		for (i = 0; i < 200 && rp1 !== 1'b1; i++) step(1);
		for (i = 0; i < 200 && rd1 !== 1'b1; i++) step(1);
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ----------
	// Scenarios
	// ----------
	// Default dual role toggles, then meets a sink behind an active cable
	task automatic t_drp();
		rd(8'h0A, d);
		chk("role rst", d, 8'h00);
		rd(8'h55, d);
		chk("unmapped", d, 8'h00);
		chk("i2c mode", {7'h00, gm}, 8'h00);
		a = 1'b0;
		b = 1'b0;
		for (i = 0; i < 300; i++)
		begin
			step(1);
			if (rp1 && rp2) a = 1'b1;
			if (rd1 && rd2) b = 1'b1;
		end
		chk("drp rp", {7'h00, a}, 8'h01);
		chk("drp rd", {7'h00, b}, 8'h01);
		kind = 3'h1;
		for (i = 0; i < 400 && att !== 1'b1; i++) step(1);
		step(2);
		chk("attach", {7'h00, att}, 8'h01);
		chk("vconn", {6'h00, vc1, vc2}, 8'h02);
		chk("orient", {7'h00, ori}, 8'h00);
		chk("irq", {7'h00, irq}, 8'h01);
		wr(8'h09, 8'h10);
		step(2);
		chk("irq clr", {7'h00, irq}, 8'h00);
		// Cable leaves while the sink stays: VCONN must not stay on a bare pin
		kind = 3'h6;
		step(6);
		chk("vconn off", {6'h00, vc1, vc2}, 8'h00);
		kind = 3'h0;
		step(60);
	endtask

	// Source preference turns a sink-side attach to a dual-role partner around
	task automatic t_try();
		wr(8'h0A, 8'h06);
		to_sink_phase();
		kind = 3'h7;
		vbus_on = 1'b1;
		step(100);
		rd(8'h09, d);
		chk("try src", {d[7:6], 5'h00, att}, 8'h41);
		kind = 3'h0;
		vbus_on = 1'b0;
		wr(8'h0A, 8'h00);
		step(60);
	endtask

	// Source-only: fixed Rp, current steps, debug and audio accessories
	task automatic t_src();
		set_role(2'h2);
		step(150);
		chk("src term", {4'h0, rp1, rp2, rd1, rd2}, 8'h0C);
		chk("adv def", {6'h00, rpl}, 8'h00);
		for (i = 1; i < 3; i++)
		begin
			wr(8'h08, {i[1:0], 6'h00});
			step(3);
			chk("adv", {6'h00, rpl}, {6'h00, i[1:0]});
		end
		kind = 3'h3;
		step(60);
		rd(8'h08, d);
		chk("acc dbg", d & 8'h0E, 8'h0C);
		kind = 3'h0;
		step(60);
		kind = 3'h4;
		step(60);
		rd(8'h08, d);
		chk("acc audio", d & 8'h0E, 8'h08);
		chk("audio pin", {7'h00, aud}, 8'h00);
		kind = 3'h0;
		step(60);
	endtask

	// Sink-only: no attach before VBUS, then current and debug reporting
	task automatic t_snk();
		set_role(2'h1);
		kind = 3'h2;
		step(100);
		chk("snk term", {4'h0, rp1, rp2, rd1, rd2}, 8'h03);
		rd(8'h09, d);
		chk("no vbus", d & 8'hC0, 8'h00);
		vbus_on = 1'b1;
		step(60);
		chk("orient snk", {7'h00, ori}, 8'h01);
		rd(8'h08, d);
		chk("det cur", d & 8'h30, 8'h10);
		kind = 3'h0;
		vbus_on = 1'b0;
		step(60);
		kind = 3'h5;
		vbus_on = 1'b1;
		step(60);
		rd(8'h08, d);
		chk("acc dbg snk", d & 8'h0E, 8'h0E);
		kind = 3'h0;
		vbus_on = 1'b0;
		step(60);
	endtask

	// Soft reset and an enable falling edge both fall back to dual role
	task automatic t_soft();
		wr(8'h0A, 8'h28);
		step(2);
		rd(8'h0A, d);
		chk("soft rst", d, 8'h00);
		set_role(2'h2);
		enable_low_pin = 1'b1;
		step(10);
		enable_low_pin = 1'b0;
		step(8);
		rd(8'h0A, d);
		chk("en fall", d & 8'h30, 8'h00);
	endtask

	// Floating strap: role writes and high current are ignored, pins report
	task automatic t_gpio();
		addr_float_pin = 1'b1;
		do_reset();
		chk("gpio", {7'h00, gm}, 8'h01);
		wr(8'h08, 8'h80);
		wr(8'h0A, 8'h21);
		wr(8'h0A, 8'h26);
		b = 1'b0;
		for (i = 0; i < 300; i++)
		begin
			step(1);
			if (rd1 && rd2) b = 1'b1;
		end
		chk("gpio drp", {7'h00, b}, 8'h01);
		kind = 3'h1;
		for (i = 0; i < 400 && att !== 1'b1; i++) step(1);
		step(2);
		chk("gpio adv", {6'h00, rpl}, 8'h00);
		chk("gpio irq", {7'h00, irq}, 8'h00);
		kind = 3'h0;
		step(60);
		kind = 3'h4;
		for (i = 0; i < 400 && aud !== 1'b1; i++) step(1);
		chk("gpio audio", {7'h00, aud}, 8'h01);
		kind = 3'h0;
		step(60);
		kind = 3'h2;
		vbus_on = 1'b1;
		for (i = 0; i < 400 && ori !== 1'b1; i++) step(1);
		step(2);
		chk("gpio cur", {6'h00, ca, cb}, 8'h02);
		// Preference written above must not apply: a dual-role partner ends as our source
		kind = 3'h0;
		vbus_on = 1'b0;
		step(60);
		to_sink_phase();
		kind = 3'h7;
		vbus_on = 1'b1;
		step(100);
		chk("gpio no try", {4'h0, att, ori, ca, cb}, 8'h05);
	endtask

	// Main sequence
	initial
	begin
		failures = 0;
		n_tests = 0;
		sys_rst = 1'b1;
		enable_low_pin = 1'b0;
		addr_float_pin = 1'b0;
		vbus_on = 1'b0;
		kind = 3'h0;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		do_reset();
		t_drp();
		t_try();
		t_src();
		t_snk();
		t_soft();
		t_gpio();
		close_out();
	end

	// Watchdog well beyond the few thousand cycles the scenarios need
	initial
	begin
		repeat (20000) @(posedge clk);
		failures++;
		close_out();
	end
endmodule
`default_nettype wire

// file: tb/tcpr_far_model.sv
// Far-side Type-C partner model seen through the CC comparator codes
`timescale 1ns/10ps
`default_nettype none
module tcpr_far_model
	import tcpr_pkg::*;
(
	input wire logic [2:0] kind,
	input wire logic vbus_on,
	input wire logic cc1_rp_en,
	input wire logic cc2_rp_en,
	input wire logic cc1_rd_en,
	input wire logic cc2_rd_en,
	output logic [2:0] cc1_level,
	output logic [2:0] cc2_level,
	output logic vbus_det_pin
);
	// ----------
	// Partner kinds
	// ----------
	// 0 none, 1 sink on CC2 with Ra cable on CC1, 2 source at 1.5 A on CC1,
	// 3 Rd on both, 4 audio adapter, 5 Rp on both, 6 sink on CC2 without cable,
	// 7 dual-role partner on CC1 that takes whichever role the device leaves it.
	// Like terminations facing each other read as open, so the partner is
	// only seen while the device shows the opposite pull.
	always_comb
	begin
		cc1_level = CC_OPEN;
		cc2_level = CC_OPEN;
		case (kind)
			3'h1, 3'h6:
			begin
				if (cc2_rp_en) cc2_level = CC_RD;
				if (cc1_rp_en && kind == 3'h1) cc1_level = CC_RA;
			end
			3'h2: if (cc1_rd_en) cc1_level = CC_RP_MED;
			3'h3:
			begin
				if (cc1_rp_en) cc1_level = CC_RD;
				if (cc2_rp_en) cc2_level = CC_RD;
			end
			3'h4:
			begin
				if (cc1_rp_en) cc1_level = CC_AUDIO;
				if (cc2_rp_en) cc2_level = CC_AUDIO;
			end
			3'h5:
			begin
				if (cc1_rd_en) cc1_level = CC_RP_DEF;
				if (cc2_rd_en) cc2_level = CC_RP_DEF;
			end
			3'h7:
			begin
				if (cc1_rp_en) cc1_level = CC_RD;
				else if (cc1_rd_en) cc1_level = CC_RP_DEF;
			end
			default: cc1_level = CC_OPEN;
		endcase
	end

	// A source powers VBUS only when told, so a sink can be left waiting
	// The dual-role partner only powers VBUS while it is the source
	assign vbus_det_pin = vbus_on && (kind == 3'h2 || kind == 3'h5 || (kind == 3'h7 && cc1_rd_en));
endmodule
`default_nettype wire
